// *** inc/sfpw_pkg.sv ***
package sfpw_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int PAGE_BYTES = 256;
    localparam int COL_W = 8;
    localparam int PAGE_W = 11;
    localparam int ADDR_W = 24;
    localparam int PAGE_LSB = 8;
    localparam int SECTOR_LSB = 8;
    localparam int SECTOR_W = 3;
    localparam logic [2:0] TOP_SECTOR = 3'h7;
    localparam int FIFO_DEPTH = 8;

    // ****************************************************************
    // Instruction codes (values are arbitrary)
    // ****************************************************************
    localparam logic [7:0] CMD_ARM = 8'hA1;
    localparam logic [7:0] CMD_REWRITE = 8'hA2;
    localparam logic [7:0] CMD_BURN = 8'hA3;
    localparam logic [7:0] CMD_STATUS = 8'hA4;

    // ****************************************************************
    // Header and status layout
    // ****************************************************************
    localparam logic [2:0] HDR_BYTES = 3'h4;
    localparam int ST_ACTIVE = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_PROT_LSB = 2;
    localparam logic [2:0] PROT_RESET = 3'h0;
    localparam logic [5:0] SYNC_RESET = 6'h38;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {ARR_READ, ARR_ERASE, ARR_PROG} sfpw_op_t;

    typedef struct packed {
        logic [COL_W-1:0] col;
        logic [7:0] data;
    } sfpw_byte_t;

    typedef struct packed {
        sfpw_op_t op;
        logic [PAGE_W-1:0] page;
        logic [COL_W-1:0] col;
        logic [7:0] wdata;
    } sfpw_req_t;

    // Level 0 protects nothing, levels 1 to 3 the top 2^(n-1) sectors, levels 4 to 7 all eight.
    function automatic logic sfpw_protected(input logic [2:0] level,
                                            input logic [2:0] sector);
        logic [3:0] span;
        span = 4'h0;
        if (level != 3'h0)
        begin
            span = (level >= 3'h4) ? 4'h8 : 4'(1 << (level - 3'h1));
        end
        return (4'h8 - {1'b0, sector}) <= span;
    endfunction : sfpw_protected

endpackage : sfpw_pkg

// *** design/sfpw_fifo.sv ***
`timescale 1ns/100ps
module sfpw_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    wire doPush = in_valid && in_ready;
    wire doPop = out_valid && out_ready;

    assign in_ready = count != (PW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rdPtr];

    always_ff @(posedge clk)
    begin
        if (doPush)
        begin
            mem[wrPtr] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            wrPtr <= doPush ? PW'((wrPtr + 1'b1) % DEPTH) : wrPtr;
            rdPtr <= doPop ? PW'((rdPtr + 1'b1) % DEPTH) : rdPtr;
            count <= count + (PW+1)'(doPush) - (PW+1)'(doPop);
        end
    end
endmodule : sfpw_fifo

// *** design/sfpw_front_end.sv ***
`timescale 1ns/100ps
module sfpw_front_end (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic reset_pin_n,
    input wire logic area_freeze_pin_n,
    input wire logic top_block_lock_n,
    input wire logic [2:0] protect_level_in,
    output logic array_req,
    output sfpw_pkg::sfpw_req_t array_cmd,
    input wire logic array_ack,
    input wire logic [7:0] array_rdata,
    output logic cycle_active_flag,
    output logic modify_armed_latch,
    output logic [2:0] protect_level_bits
);
    import sfpw_pkg::*;

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    typedef enum {S_IDLE, S_DRAIN, S_MERGE, S_ERASE, S_PROG} sfpw_state_t;

    logic [5:0] syncA;
    logic [5:0] syncB;
    logic sclkPrev;
    logic csPrev;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            syncA <= SYNC_RESET;
            syncB <= SYNC_RESET;
            sclkPrev <= 1'b0;
            csPrev <= 1'b0;
        end
        else
        begin
            syncA <= {top_block_lock_n, area_freeze_pin_n, reset_pin_n,
                      spi_mosi, spi_cs_n, spi_sclk};
            syncB <= syncA;
            sclkPrev <= syncB[0];
            csPrev <= syncB[1];
        end
    end

    wire sclkNow = syncB[0];
    wire csNow = syncB[1];
    wire mosiNow = syncB[2];
    wire lockNow = syncB[5];
    wire freezeNow = syncB[4];
    wire rst = sys_rst || !syncB[3];
    wire sclkRise = sclkNow && !sclkPrev;
    wire sclkFall = !sclkNow && sclkPrev;
    wire csFall = !csNow && csPrev;
    wire csRise = csNow && !csPrev;

    // ****************************************************************
    // Frame tracking
    // ****************************************************************
    logic primed;
    logic active;
    logic [2:0] bitCnt;
    logic [2:0] byteCnt;
    logic [7:0] shiftIn;
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [COL_W-1:0] dataIdx;
    logic gotData;
    logic overrun;
    sfpw_state_t state;
    logic armed;
    logic [2:0] protLevel;

    wire idle = state == S_IDLE;
    wire [7:0] rxByte = {shiftIn[6:0], mosiNow};
    wire bitTake = active && sclkRise;
    wire byteDone = bitTake && bitCnt == 3'h7;
    wire isWriteOp = opcode == CMD_REWRITE || opcode == CMD_BURN;
    wire inData = byteCnt == HDR_BYTES;
    wire pushValid = byteDone && inData && isWriteOp && idle;
    wire pushReady;
    sfpw_byte_t pushByte;

    assign pushByte.col = addr[COL_W-1:0] + dataIdx;
    assign pushByte.data = rxByte;

    // fall needed after select seen high
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            primed <= 1'b0;
            active <= 1'b0;
        end
        else
        begin
            primed <= primed || csNow;
            active <= (active && !csRise) || (csFall && primed);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || csFall)
        begin
            bitCnt <= 3'h0;
            byteCnt <= 3'h0;
            dataIdx <= '0;
            gotData <= 1'b0;
            overrun <= 1'b0;
        end
        else if (byteDone)
        begin
            bitCnt <= 3'h0;
            byteCnt <= inData ? byteCnt : byteCnt + 3'h1;
            dataIdx <= pushValid ? dataIdx + 8'h01 : dataIdx;
            gotData <= gotData || pushValid;
            overrun <= overrun || (pushValid && !pushReady);
        end
        else if (bitTake)
        begin
            bitCnt <= bitCnt + 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shiftIn <= 8'h00;
            opcode <= 8'h00;
            addr <= '0;
        end
        else if (bitTake)
        begin
            shiftIn <= rxByte;
            opcode <= (byteDone && byteCnt == 3'h0) ? rxByte : opcode;
            if (byteDone && byteCnt != 3'h0 && !inData)
            begin
                addr <= {addr[ADDR_W-9:0], rxByte};
            end
        end
    end

    // ****************************************************************
    // Instruction acceptance and protection
    // ****************************************************************
    wire [PAGE_W-1:0] pageAddr = addr[PAGE_LSB+PAGE_W-1:PAGE_LSB];
    wire [SECTOR_W-1:0] sector = pageAddr[SECTOR_LSB+SECTOR_W-1:SECTOR_LSB];
    wire endInst = active && csRise;
    wire frameOk = bitCnt == 3'h0;
    wire armCmd = endInst && frameOk && opcode == CMD_ARM
                  && byteCnt == 3'h1 && idle;
    wire wrCmd = endInst && frameOk && isWriteOp && inData && gotData
                 && armed && !overrun && idle;
    wire lockHit = !lockNow && sector == TOP_SECTOR;
    wire blocked = lockHit || sfpw_protected(protLevel, sector);
    wire startWrite = wrCmd && !blocked;
    wire progLast = state == S_PROG && array_ack && array_cmd.col == 8'hFF;

    // arm sets; completion or protection refusal clears
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            armed <= 1'b0;
        end
        else
        begin
            armed <= armCmd || (armed && !progLast && !(wrCmd && blocked));
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            protLevel <= PROT_RESET;
        end
        else if (freezeNow)
        begin
            protLevel <= protect_level_in;
        end
    end

    // ****************************************************************
    // Byte FIFO and page buffer
    // ****************************************************************
    logic [7:0] pageBuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] modMask;
    logic isBurn;
    logic [PAGE_W-1:0] curPage;
    logic [COL_W-1:0] col;
    logic reqArm;
    logic [7:0] progByte;
    wire popValid;
    wire popReady = state == S_IDLE || state == S_DRAIN;
    wire [15:0] popRaw;
    sfpw_byte_t popByte;

    assign popByte = sfpw_byte_t'(popRaw);

    sfpw_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(rst),
        .in_valid(pushValid),
        .in_ready(pushReady),
        .in_data(16'(pushByte)),
        .out_valid(popValid),
        .out_ready(popReady),
        .out_data(popRaw)
    );

    wire doPop = popValid && popReady;
    wire mergeAck = state == S_MERGE && array_ack;
    // burn ANDs new data into old contents
    // unmodified bytes take old page values
    wire [7:0] oldByte = pageBuf[col];
    wire [7:0] mergedByte = !modMask[col] ? array_rdata
                          : isBurn ? (oldByte & array_rdata) : oldByte;

    // one page of buffer, any byte
    always_ff @(posedge clk)
    begin
        if (doPop)
        begin
            pageBuf[popByte.col] <= popByte.data;
        end
        else if (mergeAck)
        begin
            pageBuf[col] <= mergedByte;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || (csFall && idle))
        begin
            modMask <= '0;
        end
        else if (doPop)
        begin
            modMask[popByte.col] <= 1'b1;
        end
    end

    // ****************************************************************
    // Write cycle sequencer
    // ****************************************************************
    sfpw_state_t next_state;
    wire lastCol = col == 8'hFF;

    always_comb
    begin
        next_state = state;
        unique case (state)
            S_IDLE: next_state = startWrite ? S_DRAIN : S_IDLE;
            S_DRAIN: next_state = popValid ? S_DRAIN : S_MERGE;
            S_MERGE:
            begin
                if (array_ack && lastCol)
                begin
                    next_state = isBurn ? S_PROG : S_ERASE;
                end
            end
            S_ERASE: next_state = array_ack ? S_PROG : S_ERASE;
            S_PROG: next_state = (array_ack && lastCol) ? S_IDLE : S_PROG;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= S_IDLE;
            col <= '0;
            reqArm <= 1'b0;
            isBurn <= 1'b0;
            curPage <= '0;
        end
        else
        begin
            state <= next_state;
            col <= (state != next_state) ? 8'h00
                 : (array_ack ? col + 8'h01 : col);
            reqArm <= !array_ack && state == next_state
                      && (state == S_MERGE || state == S_ERASE
                          || state == S_PROG);
            isBurn <= startWrite ? opcode == CMD_BURN : isBurn;
            curPage <= startWrite ? pageAddr : curPage;
        end
    end

    always_ff @(posedge clk)
    begin
        progByte <= pageBuf[col];
    end

    assign array_req = reqArm;
    assign array_cmd.op = state == S_MERGE ? ARR_READ
                        : state == S_ERASE ? ARR_ERASE : ARR_PROG;
    assign array_cmd.page = curPage;
    assign array_cmd.col = col;
    assign array_cmd.wdata = progByte;

    // ****************************************************************
    // Status output
    // ****************************************************************
    logic [7:0] outShift;
    logic misoBit;
    logic sending;
    logic oeReg;
    wire [7:0] statusByte = {3'h0, protLevel, armed, !idle};
    wire statusStart = byteDone && byteCnt == 3'h0 && rxByte == CMD_STATUS;

    always_ff @(posedge clk)
    begin
        if (rst || csFall)
        begin
            sending <= 1'b0;
            outShift <= 8'h00;
        end
        else if (statusStart || (sending && byteDone))
        begin
            sending <= 1'b1;
            outShift <= statusByte;
        end
        else if (active && sclkFall)
        begin
            outShift <= {outShift[6:0], 1'b0};
        end
    end

    // shift on falling, drive only when selected
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            misoBit <= 1'b0;
            oeReg <= 1'b0;
        end
        else
        begin
            misoBit <= (active && sclkFall) ? outShift[7] : misoBit;
            oeReg <= active && !csNow && sending;
        end
    end

    assign spi_miso = misoBit;
    assign spi_miso_oe = oeReg;
    // busy from cycle start to end
    assign cycle_active_flag = !idle;
    assign modify_armed_latch = armed;
    assign protect_level_bits = protLevel;
endmodule : sfpw_front_end

// *** verification/sfpw_front_end_assertions.sv ***
`timescale 1ns/100ps
// ********
// Port checker of the front end.
// ********
module sfpw_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic spi_miso_oe,
    input wire logic reset_pin_n,
    input wire logic area_freeze_pin_n,
    input wire logic top_block_lock_n,
    input wire logic array_req,
    input sfpw_pkg::sfpw_req_t array_cmd,
    input wire logic array_ack,
    input wire logic cycle_active_flag,
    input wire logic modify_armed_latch,
    input wire logic [2:0] protect_level_bits
);
    import sfpw_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_oe_off: assert property (spi_cs_n [*5] |-> !spi_miso_oe)
        else $error("output enabled while deselected");
    a_pin_reset: assert property (!reset_pin_n [*4] |->
        !modify_armed_latch && !spi_miso_oe)
        else $error("pin reset left latch or output on");
    a_freeze_hold: assert property (!area_freeze_pin_n [*4] |=>
        $stable(protect_level_bits))
        else $error("protect level moved while frozen");
    a_top_lock: assert property (!top_block_lock_n [*4] |->
        !(array_req && array_cmd.op != ARR_READ &&
        array_cmd.page[10:8] == TOP_SECTOR))
        else $error("locked top sector modified");
    a_cmd_hold: assert property (array_req && !array_ack |=>
        array_req && $stable(array_cmd))
        else $error("array request changed before ack");
    a_ack_drop: assert property (array_ack |=> !array_req)
        else $error("array request held after ack");
    a_busy_req: assert property (array_req |-> cycle_active_flag)
        else $error("array used while flag low");
    a_start_armed: assert property ($rose(cycle_active_flag) |->
        $past(modify_armed_latch))
        else $error("cycle started without arm");
    a_end_clear: assert property ($fell(cycle_active_flag) |->
        ##[0:3] !modify_armed_latch)
        else $error("latch not cleared after cycle");
    a_cs_start: assert property ($rose(cycle_active_flag) |->
        spi_cs_n && $past(spi_cs_n, 2))
        else $error("cycle started while selected");

    c_write: cover property ($rose(cycle_active_flag));
    c_erase: cover property (array_req && array_cmd.op == ARR_ERASE);
    c_status: cover property ($rose(spi_miso_oe));
endmodule : sfpw_assertions

// *** verification/sfpw_array_model.sv ***
`timescale 1ns/100ps
// ********
// Page array model, prompt or slow to acknowledge.
// ********
module sfpw_array_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slowMode,
    input wire logic array_req,
    input sfpw_pkg::sfpw_req_t array_cmd,
    output logic array_ack,
    output logic [7:0] array_rdata
);
    import sfpw_pkg::*;
    logic [7:0] mem [logic [18:0]];
    int waitCnt;

    function automatic logic [7:0] peek(input logic [18:0] k);
        return mem.exists(k) ? mem[k] : 8'hFF;
    endfunction : peek

    initial array_ack = 1'b0;
    initial array_rdata = 8'h00;

    // Idle read data toggles so a stale byte is never mistaken for data.
    always @(posedge clk)
    begin
        array_ack <= 1'b0;
        array_rdata <= ~array_rdata;
        if (sys_rst)
        begin
            waitCnt <= 0;
        end
        else if (array_req && !array_ack)
        begin
            if (waitCnt < (slowMode ? 3 : 0))
            begin
                waitCnt <= waitCnt + 1;
            end
            else
            begin
                waitCnt <= 0;
                array_ack <= 1'b1;
                case (array_cmd.op)
                    ARR_READ: array_rdata <= peek({array_cmd.page,
                        array_cmd.col});
                    ARR_ERASE:
                        for (int i = 0; i < PAGE_BYTES; i++)
                            mem[{array_cmd.page, 8'(i)}] = 8'hFF;
                    default: mem[{array_cmd.page, array_cmd.col}] =
                        peek({array_cmd.page, array_cmd.col}) &
                        array_cmd.wdata;
                endcase
            end
        end
    end
endmodule : sfpw_array_model

// *** verification/sfpw_front_end_tb_top.sv ***
`timescale 1ns/100ps
// ********
// Bench driving the serial pins as a bus master.
// ********
module sfpw_front_end_tb_top;
    import sfpw_pkg::*;
    typedef logic [7:0] sfpw_bytes_t [$];
    localparam int PH = 6;
    logic clk, sys_rst, spiSclk, spiCsN, spiMosi, spiMiso, spiMisoOe;
    logic resetPinN, freezeN, lockN, slowMode, arrayReq, arrayAck;
    logic cycleActive, armed;
    logic [2:0] protLevelIn, protBits;
    logic [7:0] arrayRdata, rxByte;
    sfpw_req_t arrayCmd;
    int errors, comparisons;

    sfpw_front_end dut_u (
        .clk(clk), .sys_rst(sys_rst), .spi_sclk(spiSclk),
        .spi_cs_n(spiCsN), .spi_mosi(spiMosi), .spi_miso(spiMiso),
        .spi_miso_oe(spiMisoOe), .reset_pin_n(resetPinN),
        .area_freeze_pin_n(freezeN), .top_block_lock_n(lockN),
        .protect_level_in(protLevelIn), .array_req(arrayReq),
        .array_cmd(arrayCmd), .array_ack(arrayAck),
        .array_rdata(arrayRdata), .cycle_active_flag(cycleActive),
        .modify_armed_latch(armed), .protect_level_bits(protBits)
    );

    sfpw_array_model model_u (
        .clk(clk), .sys_rst(sys_rst), .slowMode(slowMode),
        .array_req(arrayReq), .array_cmd(arrayCmd),
        .array_ack(arrayAck), .array_rdata(arrayRdata)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask : ticks

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done

    // Static pins and array speed change together, off the sampling edge.
    task automatic pins(input logic rstN, input logic frzN,
                        input logic lckN, input logic [2:0] lvl,
                        input logic slow);
        resetPinN <= rstN;
        freezeN <= frzN;
        lockN <= lckN;
        protLevelIn <= lvl;
        slowMode <= slow;
    endtask : pins

    // Clock parks at the mode's idle level.
    task automatic frame(input logic mode3, input sfpw_bytes_t b,
                         input int extra);
        int n;
        n = 8 * b.size() + extra;
        spiSclk <= mode3;
        ticks(PH);
        spiCsN <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            ticks(PH);
            spiMosi <= (i < 8 * b.size()) ? b[i / 8][7 - i % 8] : 1'b0;
            spiSclk <= 1'b0;
            ticks(PH);
            rxByte = {rxByte[6:0], spiMiso};
            spiSclk <= 1'b1;
        end
        ticks(PH);
        spiSclk <= mode3;
        ticks(PH);
        spiCsN <= 1'b1;
        ticks(PH);
    endtask : frame

    task automatic status(input logic mode3);
        frame(mode3, '{CMD_STATUS, 8'h00}, 0);
    endtask : status

    task automatic wait_idle;
        for (int i = 0; i < 20000; i++)
        begin
            @(posedge clk);
            if (cycleActive === 1'b0)
                return;
        end
        check(cycleActive, 1'b0);
        stop_test();
    endtask : wait_idle

    initial
    begin
        errors = 0;
        comparisons = 0;
        rxByte = 8'h00;
        sys_rst <= 1'b1;
        spiSclk <= 1'b0;
        spiMosi <= 1'b0;
        spiCsN <= 1'b1;
        pins(1'b1, 1'b1, 1'b1, 3'h0, 1'b0);
        ticks(16);
        sys_rst <= 1'b0;
        ticks(8);
        // Arm, then read status in the other mode.
        frame(0, '{CMD_ARM}, 0);
        check(armed, 1'b1);
        status(1);
        check(rxByte, 8'h02);
        done("arm_status");
        model_u.mem[19'h005FE] = 8'h00;
        model_u.mem[19'h00502] = 8'h5A;
        // Whole run of bytes in one frame, wrapping from page end to column 0.
        frame(0, '{CMD_REWRITE, 8'h00, 8'h05, 8'hFE, 8'hA0, 8'hA1,
            8'hA2, 8'hA3}, 0);
        check(cycleActive, 1'b1);
        status(1);
        check(rxByte, 8'h03);
        wait_idle();
        check(armed, 1'b0);
        check(model_u.peek(19'h005FE), 8'hA0);
        check(model_u.peek(19'h005FF), 8'hA1);
        check(model_u.peek(19'h00500), 8'hA2);
        check(model_u.peek(19'h00501), 8'hA3);
        check(model_u.peek(19'h00502), 8'h5A);
        done("rewrite");
        pins(1'b1, 1'b1, 1'b1, 3'h0, 1'b1);
        frame(1, '{CMD_ARM}, 0);
        frame(1, '{CMD_BURN, 8'h00, 8'h05, 8'h02, 8'h0F}, 0);
        wait_idle();
        check(model_u.peek(19'h00502), 8'h0A);
        check(model_u.peek(19'h005FE), 8'hA0);
        done("burn");
        frame(0, '{CMD_REWRITE, 8'h00, 8'h05, 8'h10, 8'h11}, 0);
        check(cycleActive, 1'b0);
        frame(0, '{CMD_ARM}, 0);
        frame(0, '{CMD_REWRITE, 8'h00, 8'h05, 8'h10, 8'h11}, 3);
        check(cycleActive, 1'b0);
        check(model_u.peek(19'h00510), 8'hFF);
        done("refused");
        pins(1'b1, 1'b1, 1'b0, 3'h0, 1'b1);
        ticks(4);
        frame(0, '{CMD_ARM}, 0);
        frame(0, '{CMD_REWRITE, 8'h07, 8'h00, 8'h00, 8'h55}, 0);
        check(cycleActive, 1'b0);
        check(armed, 1'b0);
        pins(1'b1, 1'b1, 1'b1, 3'h0, 1'b1);
        ticks(4);
        frame(0, '{CMD_ARM}, 0);
        frame(0, '{CMD_REWRITE, 8'h07, 8'hFF, 8'h00, 8'h55}, 0);
        wait_idle();
        check(model_u.peek(19'h7FF00), 8'h55);
        done("top_lock");
        pins(1'b1, 1'b1, 1'b1, 3'h2, 1'b1);
        ticks(6);
        pins(1'b1, 1'b0, 1'b1, 3'h2, 1'b1);
        ticks(4);
        pins(1'b1, 1'b0, 1'b1, 3'h5, 1'b1);
        ticks(6);
        check(protBits, 3'h2);
        pins(1'b1, 1'b1, 1'b1, 3'h5, 1'b1);
        ticks(6);
        check(protBits, 3'h5);
        status(0);
        check(rxByte, 8'h14);
        frame(0, '{CMD_ARM}, 0);
        frame(0, '{CMD_REWRITE, 8'h00, 8'h05, 8'h10, 8'h11}, 0);
        check(cycleActive, 1'b0);
        done("freeze");
        pins(1'b1, 1'b1, 1'b1, 3'h0, 1'b1);
        frame(0, '{CMD_ARM}, 0);
        check(armed, 1'b1);
        // Host holds the reset pin low for a while.
        pins(1'b0, 1'b1, 1'b1, 3'h0, 1'b1);
        ticks(6);
        check(armed, 1'b0);
        check(spiMisoOe, 1'b0);
        pins(1'b1, 1'b1, 1'b1, 3'h0, 1'b1);
        ticks(8);
        frame(0, '{CMD_ARM}, 0);
        check(armed, 1'b1);
        done("pin_reset");
        stop_test();
    end
endmodule : sfpw_front_end_tb_top

bind sfpw_front_end sfpw_assertions chk_u (
    .clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
    .spi_miso_oe(spi_miso_oe), .reset_pin_n(reset_pin_n),
    .area_freeze_pin_n(area_freeze_pin_n),
    .top_block_lock_n(top_block_lock_n), .array_req(array_req),
    .array_cmd(array_cmd), .array_ack(array_ack),
    .cycle_active_flag(cycle_active_flag),
    .modify_armed_latch(modify_armed_latch),
    .protect_level_bits(protect_level_bits)
);
